// File: include/scp_defines.svh
// Constants of the two-wire serial control port.
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

`define SCP_ADDR_FIXED   4'hB
`define SCP_BLK_CTRL     8'h00
`define SCP_BLK_LUT      8'h01
`define SCP_CTRL_MAX     8'h3F
`define SCP_DUMMY_BYTE   8'h00
`define SCP_BITS_BYTE    4'h8
`define SCP_BIT_LAST_TX  4'h7

`endif

// File: include/scp_pkg.sv
// Types of the two-wire serial control port.
package scp_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX   = 6'h02,
        ST_ACK  = 6'h04,
        ST_TX   = 6'h08,
        ST_MACK = 6'h10,
        ST_NEXT = 6'h20
    } scp_state_t;

    typedef enum logic [1:0] {
        ROLE_ADDR = 2'h0,
        ROLE_BLK  = 2'h1,
        ROLE_BASE = 2'h2,
        ROLE_DATA = 2'h3
    } scp_role_t;

endpackage

// File: src/scp_slave.sv
// Two-wire serial slave reaching the control registers and lookup table.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"

module scp_slave (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [2:0] slave_addr_select_pins,
    output logic            wr_en,
    output logic            wr_lut,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic            rd_lut,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data
);

    logic              scl_s;
    logic              sda_s;
    logic [2:0]        sel_m_q;
    logic [2:0]        sel_q;
    logic              scl_p_q;
    logic              sda_p_q;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_ev;
    logic              stop_ev;
    scp_pkg::scp_state_t state_q, state_d;
    scp_pkg::scp_role_t  role_q, role_d;
    logic [3:0]        cnt_q, cnt_d;
    logic [7:0]        sh_q, sh_d;
    logic              oe_q, oe_d;
    logic              rw_q, rw_d;
    logic              blk_q, blk_d;
    logic [7:0]        ptr_q, ptr_d;
    logic              dummy_q, dummy_d;
    logic              wen_q, wen_d;
    logic              wlut_q, wlut_d;
    logic [7:0]        wadr_q, wadr_d;
    logic [7:0]        wdat_q, wdat_d;
    logic              load;
    logic              addr_match;

    scp_sync u_sync_scl (
        .sys_clk (sys_clk),
        .srst    (srst),
        .pin_i   (scl_i),
        .sync_o  (scl_s)
    );

    scp_sync u_sync_sda (
        .sys_clk (sys_clk),
        .srst    (srst),
        .pin_i   (sda_i),
        .sync_o  (sda_s)
    );

    // Control block saturates, the lookup table wraps through 256 entries.
    function automatic logic [7:0] next_ptr(input logic lut,
                                            input logic [7:0] p);
        if (lut) begin
            next_ptr = p + 8'h01;
        end else if (p == `SCP_CTRL_MAX) begin
            next_ptr = p;
        end else begin
            next_ptr = p + 8'h01;
        end
    endfunction

    assign scl_rise   = scl_s & ~scl_p_q;
    assign scl_fall   = ~scl_s & scl_p_q;
    assign start_ev   = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_ev    = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign addr_match = (sh_q[7:1] == {`SCP_ADDR_FIXED, sel_q});

    always_comb begin
        state_d = state_q;
        role_d  = role_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        oe_d    = oe_q;
        rw_d    = rw_q;
        blk_d   = blk_q;
        ptr_d   = ptr_q;
        dummy_d = dummy_q;
        wen_d   = 1'b0;
        wlut_d  = wlut_q;
        wadr_d  = wadr_q;
        wdat_d  = wdat_q;
        load    = 1'b0;
        if (start_ev) begin
            // Block and pointer survive a repeated start.
            state_d = scp_pkg::ST_RX;
            role_d  = scp_pkg::ROLE_ADDR;
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
        end else if (stop_ev) begin
            state_d = scp_pkg::ST_IDLE;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                scp_pkg::ST_IDLE: begin
                    oe_d = 1'b0;
                end
                scp_pkg::ST_RX: begin
                    if (scl_rise && cnt_q != `SCP_BITS_BYTE) begin
                        sh_d  = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == `SCP_BITS_BYTE) begin
                        state_d = scp_pkg::ST_ACK;
                        oe_d    = 1'b1;
                        case (role_q)
                            scp_pkg::ROLE_ADDR: begin
                                rw_d   = sh_q[0];
                                role_d = scp_pkg::ROLE_BLK;
                                if (!addr_match) begin
                                    state_d = scp_pkg::ST_IDLE;
                                    oe_d    = 1'b0;
                                end
                            end
                            scp_pkg::ROLE_BLK: begin
                                role_d = scp_pkg::ROLE_BASE;
                                blk_d  = sh_q[0];
                                if (sh_q != `SCP_BLK_CTRL &&
                                    sh_q != `SCP_BLK_LUT) begin
                                    state_d = scp_pkg::ST_IDLE;
                                    oe_d    = 1'b0;
                                    blk_d   = blk_q;
                                end
                            end
                            scp_pkg::ROLE_BASE: begin
                                role_d  = scp_pkg::ROLE_DATA;
                                ptr_d   = sh_q;
                                dummy_d = blk_q;
                                if (!blk_q && sh_q > `SCP_CTRL_MAX) begin
                                    state_d = scp_pkg::ST_IDLE;
                                    oe_d    = 1'b0;
                                    ptr_d   = ptr_q;
                                    dummy_d = dummy_q;
                                end
                            end
                            default: begin
                                wen_d  = 1'b1;
                                wlut_d = blk_q;
                                wadr_d = ptr_q;
                                wdat_d = sh_q;
                                ptr_d  = next_ptr(blk_q, ptr_q);
                            end
                        endcase
                    end
                end
                scp_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q && role_q == scp_pkg::ROLE_BLK) begin
                            load = 1'b1;
                        end else begin
                            state_d = scp_pkg::ST_RX;
                            oe_d    = 1'b0;
                        end
                    end
                end
                scp_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == `SCP_BIT_LAST_TX) begin
                            state_d = scp_pkg::ST_MACK;
                            oe_d    = 1'b0;
                        end else begin
                            sh_d  = {sh_q[6:0], 1'b0};
                            cnt_d = cnt_q + 4'h1;
                            oe_d  = ~sh_q[6];
                        end
                    end
                end
                scp_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        // A high ninth bit ends the read and SDA stays free.
                        state_d = sda_s ? scp_pkg::ST_IDLE : scp_pkg::ST_NEXT;
                    end
                end
                scp_pkg::ST_NEXT: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        load  = 1'b1;
                    end
                end
                default: begin
                    state_d = scp_pkg::ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
            if (load) begin
                // The dummy byte is sent in place of the first table read,
                // and the pointer still advances past it.
                state_d = scp_pkg::ST_TX;
                sh_d    = dummy_q ? `SCP_DUMMY_BYTE : rd_data;
                oe_d    = ~sh_d[7];
                dummy_d = 1'b0;
                ptr_d   = next_ptr(blk_q, ptr_q);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sel_m_q    <= 3'h0;
            sel_q      <= 3'h0;
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
            state_q    <= scp_pkg::ST_IDLE;
            role_q     <= scp_pkg::ROLE_ADDR;
            cnt_q      <= 4'h0;
            sh_q       <= 8'h00;
            oe_q       <= 1'b0;
            rw_q       <= 1'b0;
            blk_q      <= 1'b0;
            ptr_q      <= 8'h00;
            dummy_q    <= 1'b0;
            wen_q      <= 1'b0;
            wlut_q     <= 1'b0;
            wadr_q     <= 8'h00;
            wdat_q     <= 8'h00;
        end else begin
            // Straps are static, so two plain flops make them safe to read.
            sel_m_q    <= slave_addr_select_pins;
            sel_q      <= sel_m_q;
            scl_p_q    <= scl_s;
            sda_p_q    <= sda_s;
            state_q    <= state_d;
            role_q     <= role_d;
            cnt_q      <= cnt_d;
            sh_q       <= sh_d;
            oe_q       <= oe_d;
            rw_q       <= rw_d;
            blk_q      <= blk_d;
            ptr_q      <= ptr_d;
            dummy_q    <= dummy_d;
            wen_q      <= wen_d;
            wlut_q     <= wlut_d;
            wadr_q     <= wadr_d;
            wdat_q     <= wdat_d;
        end
    end

    // Open-drain: the pad only ever pulls low.
    assign sda_o   = 1'b0;
    assign sda_oe  = oe_q;
    assign wr_en   = wen_q;
    assign wr_lut  = wlut_q;
    assign wr_addr = wadr_q;
    assign wr_data = wdat_q;
    assign rd_lut  = blk_q;
    assign rd_addr = ptr_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    chk_addr_mismatch: assert property (state_q == scp_pkg::ST_RX &&
        role_q == scp_pkg::ROLE_ADDR && scl_fall && !start_ev && !stop_ev &&
        cnt_q == `SCP_BITS_BYTE && !addr_match
        |=> state_q == scp_pkg::ST_IDLE && !sda_oe)
        else $error("Mismatched address was acknowledged.");

    chk_base_range: assert property (state_q == scp_pkg::ST_RX &&
        role_q == scp_pkg::ROLE_BASE && scl_fall && !start_ev && !stop_ev &&
        cnt_q == `SCP_BITS_BYTE && !blk_q && sh_q > `SCP_CTRL_MAX
        |=> state_q == scp_pkg::ST_IDLE && !sda_oe && ptr_q <= `SCP_CTRL_MAX)
        else $error("Out of range base address was acknowledged.");

    chk_ctrl_saturate: assert property (wr_en && !wr_lut &&
        wr_addr == `SCP_CTRL_MAX |-> rd_addr == `SCP_CTRL_MAX)
        else $error("Control pointer passed its maximum.");

    chk_burst_step: assert property (wr_en && wr_lut
        |-> rd_addr == wr_addr + 8'h01 && wr_lut == blk_q)
        else $error("Write burst did not step the table pointer.");

    chk_read_data: assert property (load && !dummy_q && !start_ev && !stop_ev
        |=> sh_q == $past(rd_data) && sda_oe == !sh_q[7]
        ##0 state_q == scp_pkg::ST_TX)
        else $error("Read byte does not come from the pointer.");

    chk_dummy_byte: assert property (load && dummy_q && !start_ev && !stop_ev
        |=> sh_q == `SCP_DUMMY_BYTE && !dummy_q)
        else $error("Dummy table byte handled wrongly.");

    chk_dummy_once: assert property (dummy_q && load && !start_ev && !stop_ev
        |=> !dummy_q throughout (state_q != scp_pkg::ST_ACK)[*2])
        else $error("Dummy read repeated within one sequence.");

    chk_lut_wrap: assert property (load && blk_q && ptr_q == 8'hFF &&
        !start_ev && !stop_ev |=> ptr_q == 8'h00)
        else $error("Table pointer did not wrap to zero.");

    chk_nack_release: assert property (state_q == scp_pkg::ST_MACK &&
        scl_rise && sda_s && !start_ev && !stop_ev
        |=> state_q == scp_pkg::ST_IDLE && !sda_oe)
        else $error("Master no-acknowledge did not end the read.");

    chk_rstart_keep: assert property (start_ev
        |=> ptr_q == $past(ptr_q) && blk_q == $past(blk_q))
        else $error("Repeated start lost block or pointer.");

    cov_ctrl_write: cover property (wr_en && !wr_lut);
    cov_lut_write:  cover property (wr_en && wr_lut);
    cov_lut_dummy:  cover property (load && dummy_q);
    cov_read_next:  cover property (state_q == scp_pkg::ST_NEXT && scl_fall);

endmodule

`default_nettype wire

// File: src/scp_sync.sv
// Two-flop synchroniser for one pin input.
`timescale 1ns/1ps
`default_nettype none

module scp_sync (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic pin_i,
    output logic      sync_o
);

    logic meta_q;
    logic sync_q;

    // The bus idles high, so both flops come out of reset high.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

`default_nettype wire

// File: tb/scp_master.sv
// Behavioural two-wire bus master that drives the serial slave port.
`timescale 1ns/1ps
`default_nettype none

module scp_master (
    input  wire logic sys_clk,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low
);
    // Six system clocks a quarter bit keeps SCL high well past sync delay.
    localparam int QTR = 6;

    initial begin
        scl_o   = 1'b1;
        sda_low = 1'b0;
    end

    task automatic q;
        repeat (QTR) @(posedge sys_clk);
    endtask

    // SDA changes only while SCL is low, and a quarter after the fall.
    task automatic bit_cyc(input logic v, output logic s);
        sda_low <= ~v;
        q();
        scl_o <= 1'b1;
        q();
        s = sda_i;
        scl_o <= 1'b0;
        q();
    endtask

    // Serves from idle and, as a repeated start, from SCL low.
    task automatic start;
        sda_low <= 1'b0;
        q();
        scl_o <= 1'b1;
        q();
        sda_low <= 1'b1;
        q();
        scl_o <= 1'b0;
        q();
    endtask

    task automatic stop;
        sda_low <= 1'b1;
        q();
        scl_o <= 1'b1;
        q();
        sda_low <= 1'b0;
        q();
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(b[i], s);
        end
        bit_cyc(1'b1, s);
        ack = ~s;
    endtask

    // A high ack bit on the last byte ends the read.
    task automatic rbyte(output logic [7:0] b, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, b[i]);
        end
        bit_cyc(last, s);
    endtask
endmodule

`default_nettype wire

// File: tb/serial_control_port_access_bench.sv
// Self-checking bench of the serial slave port with a bus master model.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defines.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module serial_control_port_access_bench;
    logic       sys_clk = 1'b0;
    logic       srst    = 1'b1;
    logic       scl;
    logic       sda_low;
    logic       sda_o;
    logic       sda_oe;
    logic       sda;
    logic [2:0] sel;
    logic       wr_en;
    logic       wr_lut;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       rd_lut;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] lf      = 8'h5B;
    logic [7:0] m_ctrl  [64];
    logic [7:0] m_lut   [256];
    logic [7:0] e_ctrl  [64];
    logic [7:0] e_lut   [256];
    logic [7:0] r;
    logic       a;
    int         n_mismatch = 0;
    int         num_checks = 0;

    always #5 sys_clk = ~sys_clk;
    // Open drain wire with pull-up: low if either party pulls.
    assign sda = ~sda_low & ~(sda_oe & ~sda_o);
    assign rd_data = rd_lut ? m_lut[rd_addr] : m_ctrl[rd_addr[5:0]];

    scp_master i_mst (.sys_clk(sys_clk), .sda_i(sda), .scl_o(scl),
                      .sda_low(sda_low));
    scp_slave i_dut (.sys_clk(sys_clk), .srst(srst), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .slave_addr_select_pins(sel), .wr_en(wr_en), .wr_lut(wr_lut),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_lut(rd_lut),
        .rd_addr(rd_addr), .rd_data(rd_data));

    always @(posedge sys_clk) begin
        if (wr_en) begin
            if (wr_lut) m_lut[wr_addr] <= wr_data;
            else begin
                m_ctrl[wr_addr[5:0]] <= wr_data;
                `CHK("wr_addr_max", 1'b1, wr_addr <= `SCP_CTRL_MAX)
            end
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [7:0] exp_adr(input logic lut,
                                           input logic [7:0] b, input int k);
        logic [8:0] s;
        s = {1'b0, b} + 9'(k);
        if (lut) return s[7:0];
        return (s > 9'h03F) ? `SCP_CTRL_MAX : s[7:0];
    endfunction

    task automatic rnd(output logic [7:0] v);
        lf = lfsr(lf);
        v = lf;
    endtask

    task automatic set_ptr(input logic lut, input logic [7:0] b,
                           output logic ack);
        i_mst.start();
        i_mst.wbyte({`SCP_ADDR_FIXED, sel, 1'b0}, ack);
        `CHK("addr_ack", 1'b1, ack)
        i_mst.wbyte(lut ? `SCP_BLK_LUT : `SCP_BLK_CTRL, ack);
        `CHK("blk_ack", 1'b1, ack)
        i_mst.wbyte(b, ack);
    endtask

    task automatic wr_burst(input logic lut, input logic [7:0] b, input int n);
        logic [7:0] d;
        logic [7:0] ad;
        set_ptr(lut, b, a);
        `CHK("base_ack", 1'b1, a)
        for (int k = 0; k < n; k++) begin
            rnd(d);
            i_mst.wbyte(d, a);
            `CHK("data_ack", 1'b1, a)
            ad = exp_adr(lut, b, k);
            if (lut) e_lut[ad] = d;
            else e_ctrl[ad[5:0]] = d;
        end
        i_mst.stop();
    endtask

    task automatic rd_burst(input logic lut, input logic [7:0] b, input int n,
                            input logic dummy);
        logic [7:0] d;
        logic [7:0] ad;
        i_mst.start();
        i_mst.wbyte({`SCP_ADDR_FIXED, sel, 1'b1}, a);
        `CHK("rd_ack", 1'b1, a)
        if (dummy) begin
            i_mst.rbyte(d, 1'b0);
            `CHK("dummy", `SCP_DUMMY_BYTE, d)
        end
        for (int k = 0; k < n; k++) begin
            i_mst.rbyte(d, k == n - 1);
            ad = exp_adr(lut, b, k);
            `CHK("rd_byte", lut ? e_lut[ad] : e_ctrl[ad[5:0]], d)
        end
        `CHK("released", 1'b0, sda_oe)
        i_mst.stop();
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Bounds the whole run so a stuck bus cannot hang it.
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        rnd(r);
        sel <= r[2:0];
        for (int i = 0; i < 256; i++) begin
            m_lut[i] = 8'(i) ^ 8'h5A;
            e_lut[i] = 8'(i) ^ 8'h5A;
            if (i < 64) m_ctrl[i] = 8'(i);
            if (i < 64) e_ctrl[i] = 8'(i);
        end
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        i_mst.start();
        i_mst.wbyte({`SCP_ADDR_FIXED, sel ^ 3'h1, 1'b0}, a);
        `CHK("foreign_addr", 1'b0, a)
        i_mst.stop();
        set_ptr(1'b0, 8'h40, a);
        `CHK("base_over_max", 1'b0, a)
        i_mst.stop();
        for (int i = 1; i <= 3; i++) begin
            rnd(r);
            wr_burst(1'b0, r & 8'h3F, i);
        end
        wr_burst(1'b0, 8'h3E, 4);
        set_ptr(1'b0, 8'h3C, a);
        i_mst.stop();
        rd_burst(1'b0, 8'h3C, 4, 1'b0);
        rnd(r);
        set_ptr(1'b0, r & 8'h1F, a);
        rd_burst(1'b0, r & 8'h1F, 4, 1'b0);
        wr_burst(1'b1, 8'hFE, 4);
        set_ptr(1'b1, 8'hFD, a);
        i_mst.stop();
        rd_burst(1'b1, 8'hFE, 4, 1'b1);
        rd_burst(1'b1, 8'h02, 2, 1'b0);
        set_ptr(1'b1, 8'hFF, a);
        i_mst.stop();
        rd_burst(1'b1, 8'h00, 256, 1'b1);
        finish_test();
    end
endmodule

`default_nettype wire
